// ===== src/epfs_chan_avg.v
`timescale 1ns/1ps
`include "epfs_regs.vh"
module epfs_chan_avg (
	input wire sys_clk,
	input wire rstn,
	input wire sample_valid,
	input wire [15:0] sample,
	input wire slow_tick,
	output wire [15:0] level
);
	reg [21:0] fast_r;
	reg [23:0] slow_r;
	wire [15:0] mag;
	wire [21:0] fast_in;
	wire [23:0] slow_in;

	// rectify the signed sample
	assign mag = sample[15] ? (~sample + 16'h0001) : sample;
	assign fast_in = {mag, 6'h00};
	assign slow_in = {fast_r[21:6], 8'h00};
	assign level = slow_r[23:8];

	// short average per sample, long average on the slow tick
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fast_r <= 22'h000000;
			slow_r <= 24'h000000;
		end else begin
			if (sample_valid)
				fast_r <= fast_r + (fast_in >> `EPFS_FAST_SHIFT)
					- (fast_r >> `EPFS_FAST_SHIFT);
			if (slow_tick)
				slow_r <= slow_r + (slow_in >> `EPFS_SLOW_SHIFT)
					- (slow_r >> `EPFS_SLOW_SHIFT);
		end
	end
endmodule // epfs_chan_avg

// ===== src/epfs_pulse_gen.v
`timescale 1ns/1ps
module epfs_pulse_gen #(
	parameter WIDTH_CYC = 180,
	parameter CW = 20
) (
	input wire sys_clk,
	input wire rstn,
	input wire trig,
	output reg pulse_r
);
	reg [CW-1:0] cnt_r;

	// fixed high width; a trigger during a pulse is dropped
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= {CW{1'b0}};
			pulse_r <= 1'b0;
		end else if (pulse_r) begin
			if (cnt_r == WIDTH_CYC[CW-1:0] - 1'b1) begin
				pulse_r <= 1'b0;
				cnt_r <= {CW{1'b0}};
			end else begin
				cnt_r <= cnt_r + 1'b1;
			end
		end else if (trig) begin
			pulse_r <= 1'b1;
			cnt_r <= {CW{1'b0}};
		end
	end
endmodule // epfs_pulse_gen

// ===== src/epfs_regs.vh
`ifndef EPFS_REGS_VH
`define EPFS_REGS_VH
// register word offsets, matched against byte address bits 7:2
`define EPFS_ADR_CTRL 6'h00
`define EPFS_ADR_STATUS 6'h01
`define EPFS_ADR_MASK 6'h02
`define EPFS_ADR_STATE 6'h03
`define EPFS_ADR_PHASE_AVG 6'h04
`define EPFS_ADR_NEUTRAL_AVG 6'h05
// control fields
`define EPFS_CTRL_RATE_LSB 0
`define EPFS_CTRL_RATE_MSB 1
`define EPFS_CTRL_SCALE 2
`define EPFS_CTRL_GAIN 3
`define EPFS_CTRL_EN 4
`define EPFS_CTRL_RESET 5'h10
// status and mask fields
`define EPFS_ST_BILL 0
`define EPFS_ST_CF 1
`define EPFS_ST_FAULT 2
`define EPFS_ST_SWAP 3
`define EPFS_ST_RESET 4'h0
// binary division of the oscillator, exponent for rate code 00
`define EPFS_BASE_DIV_LOG 18
// extra shift that sets full-scale dc billing rate
`define EPFS_BILL_K 21
// fault thresholds: 1/16 = 6.25 %, 0.3 % of 2^15
`define EPFS_DIFF_NUM 15
`define EPFS_LIGHT_LEVEL 16'h0062
// timing
`define EPFS_CLK_MHZ 10
`define EPFS_CF_WIDTH_NS 18000
`define EPFS_CF_WIDTH_CYC ((`EPFS_CF_WIDTH_NS * `EPFS_CLK_MHZ + 999) / 1000)
`define EPFS_BILL_WIDTH_MS 90
`define EPFS_BILL_WIDTH_CYC (`EPFS_BILL_WIDTH_MS * 1000 * `EPFS_CLK_MHZ)
`define EPFS_FAULT_TAU_MS 3000
`define EPFS_SLOW_SHIFT 8
`define EPFS_FAST_SHIFT 6
`define EPFS_LPF_SHIFT 6
`define EPFS_FAULT_TICK_CYC ((`EPFS_FAULT_TAU_MS * 1000 * `EPFS_CLK_MHZ) / 256)
`define EPFS_FAULT_QUAL_MS 1000
`define EPFS_FAULT_QUAL_TICKS ((`EPFS_FAULT_QUAL_MS * 256) / `EPFS_FAULT_TAU_MS)
`endif

// ===== src/epfs_top.v
// Notes on behaviour
// - both billing outputs give active-high pulses at the averaged power rate
// - base rate is oscillator divided by 2^18, 2^17, 2^16 or 2^15
// - billing rate scales with gain, active channel current, voltage and base rate
// - gain select multiplies the current channel by 1 or 16
// - calibration to billing ratio follows scale and rate select codes
// - calibration pulses use the same power with much shorter accumulation
// - full-scale ac maxima follow from the rate and scale settings
// - ac maximum is half the dc maximum for the same setting
// - fault raised when phase and neutral levels differ over 6.25 percent
// - during a fault billing uses the larger current channel
// - bill on phase at reset; fault about one second after start
// - fault detection suppressed below 0.3 percent of full scale
// - inactive below 93.75 percent of active raises fault, no swap
// - both channels filtered so fault follows after about three seconds
// - fault flag independent of billing pulse activity
// - inactive over active by 6.25 percent raises fault and swaps
// - no swap back until difference exceeds 6.25 percent the other way
// - fault clears once channels are within 6.25 percent again
`timescale 1ns/1ps
`include "epfs_regs.vh"
module epfs_top #(
	parameter BILL_K = `EPFS_BILL_K,
	parameter BILL_WIDTH_CYC = `EPFS_BILL_WIDTH_CYC,
	parameter FAULT_TICK_CYC = `EPFS_FAULT_TICK_CYC,
	parameter QUAL_TICKS = `EPFS_FAULT_QUAL_TICKS
) (
	input wire sys_clk,
	input wire rstn,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [3:0] wb_sel_i,
	input wire wb_we_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire [15:0] phase_current_input,
	input wire [15:0] neutral_current_input,
	input wire [15:0] voltage_input,
	input wire sample_valid,
	output wire billing_pulse_out_a,
	output wire billing_pulse_out_b,
	output wire calibration_pulse_out,
	output reg fault_out,
	output reg neutral_active_out,
	output reg irq
);
	localparam [5:0] BILL_K6 = BILL_K;
	localparam [5:0] DIV_LOG = `EPFS_BASE_DIV_LOG;
	localparam [19:0] CF_W = `EPFS_CF_WIDTH_CYC;
	localparam [19:0] DIFF_NUM = `EPFS_DIFF_NUM;
	localparam signed [23:0] LPF_RND = (1 << `EPFS_LPF_SHIFT) - 1;

	reg [4:0] ctrl_r;
	reg [3:0] status_r;
	reg [3:0] status_nxt;
	reg [3:0] mask_r;
	reg [23:0] pfilt_r;
	reg [40:0] acc_r;
	reg [40:0] acc_nxt;
	reg [10:0] bill_cnt_r;
	reg cf_trig_r;
	reg bill_trig_r;
	reg [16:0] tick_cnt_r;
	reg slow_tick_r;
	reg [7:0] qual_cnt_r;
	reg fault_nxt;
	reg swap_ev;
	reg fault_ev;
	reg act_sel_nxt;
	reg [7:0] qual_nxt;

	wire [1:0] rate_sel;
	wire scale_sel;
	wire gain_sel;
	wire meter_en;
	wire [3:0] ratio_log;
	wire [5:0] cf_sh;
	wire [40:0] cf_thr;
	wire [15:0] cur_sel;
	wire [15:0] cur_gain;
	wire signed [31:0] prod;
	wire [23:0] prod_ext;
	wire signed [23:0] pf_diff;
	wire signed [23:0] pf_step;
	wire [15:0] power_pos;
	wire [31:0] chan_flat;
	wire [31:0] lvl_flat;
	wire [15:0] phase_lvl;
	wire [15:0] neutral_lvl;
	wire [15:0] act_lvl;
	wire [15:0] ina_lvl;
	wire [19:0] act_x16;
	wire [19:0] ina_x16;
	wire [19:0] act_x15;
	wire [19:0] ina_x15;
	wire light_load;
	wire below_cond;
	wire above_cond;
	wire wb_req;
	wire wb_rd_status;
	wire bill_pulse;
	wire cf_pulse;

	assign rate_sel = ctrl_r[`EPFS_CTRL_RATE_MSB:`EPFS_CTRL_RATE_LSB];
	assign scale_sel = ctrl_r[`EPFS_CTRL_SCALE];
	assign gain_sel = ctrl_r[`EPFS_CTRL_GAIN];
	assign meter_en = ctrl_r[`EPFS_CTRL_EN];

	// log2 of the calibration to billing ratio
	function [3:0] cf_ratio_log;
		input scale;
		input [1:0] rate;
		begin
			case ({scale, rate})
			3'b100: cf_ratio_log = 4'h7;
			3'b000: cf_ratio_log = 4'h6;
			3'b101: cf_ratio_log = 4'h6;
			3'b001: cf_ratio_log = 4'h5;
			3'b110: cf_ratio_log = 4'h5;
			3'b010: cf_ratio_log = 4'h4;
			3'b111: cf_ratio_log = 4'h4;
			3'b011: cf_ratio_log = 4'hb;
			default: cf_ratio_log = 4'h6;
			endcase
		end
	endfunction

	// gain of 16 with saturation at the signed limits
	function [15:0] apply_gain;
		input [15:0] x;
		input g;
		reg [19:0] w;
		begin
			w = {{4{x[15]}}, x} << 4;
			if (!g)
				apply_gain = x;
			else if (w[19] && (w[18:15] != 4'hf))
				apply_gain = 16'h8000;
			else if (!w[19] && (w[18:15] != 4'h0))
				apply_gain = 16'h7fff;
			else
				apply_gain = w[15:0];
		end
	endfunction

	assign ratio_log = cf_ratio_log(scale_sel, rate_sel);
	// billing threshold 2^(K+18-rate), calibration one ratio below it
	assign cf_sh = BILL_K6 + DIV_LOG - {4'h0, rate_sel} - {2'b00, ratio_log};
	assign cf_thr = {40'h0, 1'b1} << cf_sh;

	// billed current: the active channel, then the gain stage
	assign cur_sel = neutral_active_out ? neutral_current_input
		: phase_current_input;
	assign cur_gain = apply_gain(cur_sel, gain_sel);
	assign prod = $signed(cur_gain) * $signed(voltage_input);
	assign prod_ext = {{2{prod[31]}}, prod[30:15], 6'h00};
	// negative filtered power gives no pulses
	assign power_pos = pfilt_r[23] ? 16'h0000 : pfilt_r[21:6];
	// step rounded away from zero, so the filter settles on the exact product
	assign pf_diff = $signed(prod_ext) - $signed(pfilt_r);
	assign pf_step = pf_diff[23] ? (pf_diff >>> `EPFS_LPF_SHIFT)
		: ((pf_diff + LPF_RND) >>> `EPFS_LPF_SHIFT);

	// low-pass of the instantaneous product
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pfilt_r <= 24'h000000;
		end else if (sample_valid) begin
			pfilt_r <= pfilt_r + pf_step;
		end
	end

	// power accumulation; ac input averages to half its peak product
	always @* begin
		acc_nxt = acc_r + {25'h0, power_pos};
	end

	// digital-to-frequency conversion and billing divide-down
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			acc_r <= 41'h0;
			cf_trig_r <= 1'b0;
			bill_trig_r <= 1'b0;
			bill_cnt_r <= 11'h000;
		end else begin
			cf_trig_r <= 1'b0;
			bill_trig_r <= 1'b0;
			if (!meter_en) begin
				acc_r <= 41'h0;
				bill_cnt_r <= 11'h000;
			end else if (acc_nxt >= cf_thr) begin
				acc_r <= acc_nxt - cf_thr;
				cf_trig_r <= 1'b1;
				if (bill_cnt_r >= (11'h001 << ratio_log) - 11'h001) begin
					bill_cnt_r <= 11'h000;
					bill_trig_r <= 1'b1;
				end else begin
					bill_cnt_r <= bill_cnt_r + 11'h001;
				end
			end else begin
				acc_r <= acc_nxt;
			end
		end
	end

	// calibration pulse stretcher
	epfs_pulse_gen #(
		.WIDTH_CYC(CF_W),
		.CW(20)
	) u_cf_pulse (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.trig(cf_trig_r),
		.pulse_r(cf_pulse)
	);

	// billing pulse stretcher, shared by both billing outputs
	epfs_pulse_gen #(
		.WIDTH_CYC(BILL_WIDTH_CYC),
		.CW(24)
	) u_bill_pulse (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.trig(bill_trig_r),
		.pulse_r(bill_pulse)
	);

	assign calibration_pulse_out = cf_pulse;
	assign billing_pulse_out_a = bill_pulse;
	assign billing_pulse_out_b = bill_pulse;

	// slow tick for the long channel averages
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tick_cnt_r <= 17'h00000;
			slow_tick_r <= 1'b0;
		end else if (tick_cnt_r == FAULT_TICK_CYC[16:0] - 17'h00001) begin
			tick_cnt_r <= 17'h00000;
			slow_tick_r <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 17'h00001;
			slow_tick_r <= 1'b0;
		end
	end

	assign chan_flat = {neutral_current_input, phase_current_input};

	// one averager per current channel
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_avg
			epfs_chan_avg u_avg (
				.sys_clk(sys_clk),
				.rstn(rstn),
				.sample_valid(sample_valid),
				.sample(chan_flat[16*gi+15:16*gi]),
				.slow_tick(slow_tick_r),
				.level(lvl_flat[16*gi+15:16*gi])
			);
		end
	endgenerate

	assign phase_lvl = lvl_flat[15:0];
	assign neutral_lvl = lvl_flat[31:16];
	assign act_lvl = neutral_active_out ? neutral_lvl : phase_lvl;
	assign ina_lvl = neutral_active_out ? phase_lvl : neutral_lvl;
	assign act_x16 = {act_lvl, 4'h0};
	assign ina_x16 = {ina_lvl, 4'h0};
	assign act_x15 = {4'h0, act_lvl} * DIFF_NUM;
	assign ina_x15 = {4'h0, ina_lvl} * DIFF_NUM;
	assign light_load = act_lvl < `EPFS_LIGHT_LEVEL;
	assign below_cond = ina_x16 < act_x15;
	assign above_cond = act_x16 < ina_x15;

	// fault qualification, swap and clear on the slow tick
	always @* begin
		fault_nxt = fault_out;
		act_sel_nxt = neutral_active_out;
		qual_nxt = qual_cnt_r;
		swap_ev = 1'b0;
		fault_ev = 1'b0;
		if (slow_tick_r) begin
			if (light_load || !(below_cond || above_cond)) begin
				qual_nxt = 8'h00;
				fault_nxt = 1'b0;
			end else if (qual_cnt_r < QUAL_TICKS[7:0] - 8'h01) begin
				qual_nxt = qual_cnt_r + 8'h01;
			end else begin
				fault_nxt = 1'b1;
				fault_ev = !fault_out;
				if (above_cond) begin
					act_sel_nxt = !neutral_active_out;
					swap_ev = 1'b1;
					qual_nxt = 8'h00;
				end
			end
		end
	end

	// fault state; phase channel active out of reset
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fault_out <= 1'b0;
			neutral_active_out <= 1'b0;
			qual_cnt_r <= 8'h00;
		end else begin
			fault_out <= fault_nxt;
			neutral_active_out <= act_sel_nxt;
			qual_cnt_r <= qual_nxt;
		end
	end

	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_rd_status = wb_req && !wb_we_i
		&& (wb_adr_i[7:2] == `EPFS_ADR_STATUS);

	// sticky events; a new event beats the read clear
	always @* begin
		status_nxt = status_r;
		if (wb_rd_status)
			status_nxt = 4'h0;
		status_nxt[`EPFS_ST_BILL] = status_nxt[`EPFS_ST_BILL] | bill_trig_r;
		status_nxt[`EPFS_ST_CF] = status_nxt[`EPFS_ST_CF] | cf_trig_r;
		status_nxt[`EPFS_ST_FAULT] = status_nxt[`EPFS_ST_FAULT] | fault_ev;
		status_nxt[`EPFS_ST_SWAP] = status_nxt[`EPFS_ST_SWAP] | swap_ev;
	end

	// wishbone slave, one wait cycle, ack drops after one cycle
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			ctrl_r <= `EPFS_CTRL_RESET;
			mask_r <= `EPFS_ST_RESET;
			status_r <= `EPFS_ST_RESET;
			irq <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
			status_r <= status_nxt;
			irq <= |(status_nxt & mask_r);
			if (wb_req && wb_we_i && wb_sel_i[0]) begin
				case (wb_adr_i[7:2])
				`EPFS_ADR_CTRL: ctrl_r <= wb_dat_i[4:0];
				`EPFS_ADR_MASK: mask_r <= wb_dat_i[3:0];
				default: ;
				endcase
			end
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i[7:2])
				`EPFS_ADR_CTRL: wb_dat_o <= {27'h0, ctrl_r};
				`EPFS_ADR_STATUS: wb_dat_o <= {28'h0, status_r};
				`EPFS_ADR_MASK: wb_dat_o <= {28'h0, mask_r};
				`EPFS_ADR_STATE: wb_dat_o <= {28'h0, qual_cnt_r != 8'h00,
					bill_pulse, neutral_active_out, fault_out};
				`EPFS_ADR_PHASE_AVG: wb_dat_o <= {16'h0, phase_lvl};
				`EPFS_ADR_NEUTRAL_AVG: wb_dat_o <= {16'h0, neutral_lvl};
				default: wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end
endmodule // epfs_top

// ===== tb/epfs_assertions.sv
`timescale 1ns/1ps
`include "epfs_regs.vh"
module epfs_assertions #(
	parameter BILL_WIDTH_CYC = 20
) (
	input wire sys_clk,
	input wire rstn,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	input wire billing_pulse_out_a,
	input wire billing_pulse_out_b,
	input wire calibration_pulse_out,
	input wire fault_out,
	input wire neutral_active_out,
	input wire irq
);
	localparam int CF_W = `EPFS_CF_WIDTH_CYC;
	logic [31:0] bh_r, ch_r;
	// high-time counters, so widths need no long repetition
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			bh_r <= 32'h0;
			ch_r <= 32'h0;
		end else begin
			bh_r <= billing_pulse_out_a ? bh_r + 32'h1 : 32'h0;
			ch_r <= calibration_pulse_out ? ch_r + 32'h1 : 32'h0;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	a_bill_same: assert property (
		billing_pulse_out_a == billing_pulse_out_b)
		else $error("billing outputs differ");
	a_bill_width: assert property (
		$fell(billing_pulse_out_a) |-> bh_r == BILL_WIDTH_CYC)
		else $error("billing pulse width wrong");
	a_cf_width: assert property (
		$fell(calibration_pulse_out) |-> ch_r == CF_W)
		else $error("calibration pulse width wrong");
	a_bill_with_cf: assert property (
		$rose(billing_pulse_out_a) |-> ##[0:2] calibration_pulse_out)
		else $error("billing pulse without calibration pulse");
	a_ack_timing: assert property (
		$rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
		else $error("ack not one cycle after request");
	a_ack_cause: assert property (
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i) ##1 !wb_ack_o)
		else $error("ack without request or too long");
	a_reset_quiet: assert property (!$past(rstn) |-> !(fault_out ||
		neutral_active_out || irq || billing_pulse_out_a))
		else $error("outputs active after reset");
	a_swap_fault: assert property (
		$changed(neutral_active_out) |-> ##[0:1] fault_out)
		else $error("channel swap without fault");
	a_fault_steady: assert property (
		$changed(fault_out) |=> $stable(fault_out) [*8])
		else $error("fault flag changes too fast");
	c_fault: cover property ($rose(fault_out));
	c_swap: cover property ($rose(neutral_active_out));
	c_irq: cover property ($rose(irq));
endmodule // epfs_assertions
bind epfs_top epfs_assertions #(.BILL_WIDTH_CYC(BILL_WIDTH_CYC)) chk_u (
	.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .irq(irq),
	.billing_pulse_out_a(billing_pulse_out_a),
	.billing_pulse_out_b(billing_pulse_out_b),
	.calibration_pulse_out(calibration_pulse_out),
	.fault_out(fault_out), .neutral_active_out(neutral_active_out)
);

// ===== tb/epfs_pulse_counter.sv
`timescale 1ns/1ps
module epfs_pulse_counter (
	input wire sys_clk,
	input wire rstn,
	input wire cf_in,
	input wire bill_in,
	output logic [31:0] cf_cnt,
	output logic [31:0] bill_cnt,
	output logic [31:0] cf_per,
	output logic [31:0] cf_bill
);
	logic cf_d_r, bill_d_r;
	logic [31:0] gap_r, run_r;
	wire cf_up = cf_in && !cf_d_r;
	wire bill_up = bill_in && !bill_d_r;
	// counts edges like a meter counter, cf period, cf pulses per bill
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			{cf_d_r, bill_d_r} <= 2'h0;
			{gap_r, run_r, cf_cnt, bill_cnt, cf_per, cf_bill} <= 192'h0;
		end else begin
			cf_d_r <= cf_in;
			bill_d_r <= bill_in;
			gap_r <= cf_up ? 32'h1 : gap_r + 32'h1;
			run_r <= bill_up ? 32'h0 : run_r + {31'h0, cf_up};
			if (cf_up) begin
				cf_cnt <= cf_cnt + 32'h1;
				cf_per <= gap_r;
			end
			if (bill_up) begin
				bill_cnt <= bill_cnt + 32'h1;
				cf_bill <= run_r + {31'h0, cf_up};
			end
		end
	end
endmodule // epfs_pulse_counter

// ===== tb/epfs_top_tb.sv
`timescale 1ns/1ps
`include "epfs_regs.vh"
module epfs_top_tb;
	logic sys_clk, rstn, we, cyc, stb, sv;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wd, q;
	logic [15:0] ph, ne, vo;
	wire [31:0] rd, cf_cnt, bill_cnt, cf_per, cf_bill;
	wire ack, bill_a, bill_b, cf, fault, nact, irq;
	int err_total, checked;
	epfs_top #(.BILL_K(12), .BILL_WIDTH_CYC(20), .FAULT_TICK_CYC(16),
		.QUAL_TICKS(3)) dut_u (
		.sys_clk(sys_clk), .rstn(rstn), .wb_adr_i(adr), .wb_dat_i(wd),
		.wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_dat_o(rd), .wb_ack_o(ack), .phase_current_input(ph),
		.neutral_current_input(ne), .voltage_input(vo),
		.sample_valid(sv), .billing_pulse_out_a(bill_a),
		.billing_pulse_out_b(bill_b), .calibration_pulse_out(cf),
		.fault_out(fault), .neutral_active_out(nact), .irq(irq));
	epfs_pulse_counter cnt_u (.sys_clk(sys_clk), .rstn(rstn), .cf_in(cf),
		.bill_in(bill_a), .cf_cnt(cf_cnt), .bill_cnt(bill_cnt),
		.cf_per(cf_per), .cf_bill(cf_bill));
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	task complete_run();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// compare with optional tolerance for measured periods
	task check(input string nm, input logic [31:0] s, e, input int t);
		checked++;
		if (!(s === e || (t > 0 && !$isunknown(s) && s + t >= e &&
			s <= e + t))) begin
			err_total++;
			$display("MISMATCH %s expected %0h seen %0h", nm, e, s);
		end
	endtask
	// classic wishbone single cycle, held until ack
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d = 0);
		int n;
		n = 0;
		@(posedge sys_clk);
		{cyc, stb, we, adr, wd, sel} <= {2'h3, w, a, d, 4'hf};
		do begin
			@(posedge sys_clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rd;
		{cyc, stb} <= 2'h0;
		check("ack", n < 50, 1'b1, 0);
		if (n >= 50) complete_run();
	endtask
	function automatic logic hit(input int k, input logic [31:0] t);
		case (k)
			0: return fault === t[0];
			1: return nact === t[0];
			2: return cf_cnt >= t;
			default: return bill_cnt >= t;
		endcase
	endfunction
	// bounded wait for a flag or a pulse count
	task wait_until(input int k, input logic [31:0] t, input int lim);
		int n;
		n = 0;
		while (!hit(k, t) && n < lim) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= lim) begin
			err_total++;
			$display("MISMATCH wait %0d expected %0h seen timeout", k, t);
			complete_run();
		end
	endtask
	// reset values, ignored writes, unmapped place, light load
	task t_regs();
		int n;
		n = 0;
		wb(1'b0, 8'h00);
		check("ctrl", q, `EPFS_CTRL_RESET, 0);
		wb(1'b0, 8'h08);
		check("mask", q, `EPFS_ST_RESET, 0);
		wb(1'b1, 8'h04, 32'hf);
		wb(1'b0, 8'h04);
		check("status", q, 32'h0, 0);
		wb(1'b1, 8'h40, 32'hff);
		wb(1'b0, 8'h40);
		check("unmapped", q, 32'h0, 0);
		repeat (8000) begin
			@(posedge sys_clk);
			n += (fault !== 1'b0);
		end
		check("light fault", n, 32'h0, 0);
	endtask
	// cf period for every scale and rate code
	task t_rates();
		logic s;
		logic [1:0] r;
		for (int i = 0; i < 8; i++) begin
			s = i[0];
			r = i[2:1] ^ 2'h3;
			ph <= (i == 0) ? 16'h0800 : 16'h4000;
			ne <= (i == 0) ? 16'h0800 : 16'h4000;
			vo <= (i == 0) ? 16'h0400 : 16'h4000;
			wb(1'b1, 8'h00, {28'h1, 1'b0, s, r});
			wait_until(2, cf_cnt + 32'h3, 12000);
			check("cf period", cf_per, (s || r == 2'h3) ? 32'h400 : 32'h800,
				8);
		end
	endtask
	// gain x16, cf pulses per billing pulse, event bits
	task t_bill();
		ph <= 16'h0800;
		ne <= 16'h0800;
		wb(1'b1, 8'h00, 32'h1f);
		wait_until(2, cf_cnt + 32'h3, 4000);
		check("gain period", cf_per, 32'h200, 8);
		wait_until(3, bill_cnt + 32'h2, 20000);
		check("bill b", bill_b, 1'b1, 0);
		check("cf per bill", cf_bill, 32'h10, 0);
		wb(1'b0, 8'h04);
		check("events", q & 32'h3, 32'h3, 0);
	endtask
	// swap to neutral, hysteresis, fault clear, no swap, interrupt
	task t_fault();
		wb(1'b1, 8'h00, 32'h17);
		wb(1'b1, 8'h08, 32'h4);
		wb(1'b0, 8'h04);
		ph <= 16'h2000;
		ne <= 16'h4000;
		wait_until(0, 32'h1, 40000);
		repeat (2) @(posedge sys_clk);
		check("swap", nact, 1'b1, 0);
		check("irq set", irq, 1'b1, 0);
		wb(1'b0, 8'h0c);
		check("state", q & 32'h3, 32'h3, 0);
		wait_until(2, cf_cnt + 32'h3, 8000);
		check("fault period", cf_per, 32'h400, 8);
		wb(1'b0, 8'h04);
		check("fault events", q & 32'hc, 32'hc, 0);
		repeat (2) @(posedge sys_clk);
		check("irq clear", irq, 1'b0, 0);
		ph <= 16'h4000;
		wait_until(0, 32'h0, 40000);
		check("hold swap", nact, 1'b1, 0);
		ne <= 16'h2000;
		wait_until(1, 32'h0, 40000);
		repeat (600) @(posedge sys_clk);
		check("no swap", {fault, nact}, 2'h2, 0);
	endtask
	initial begin
		err_total = 0;
		checked = 0;
		rstn = 1'b0;
		{cyc, stb, we, adr, wd, sel} = 47'h0;
		{ph, ne, vo} = {16'h0040, 16'h0000, 16'h4000};
		sv = 1'b1;
		repeat (20) @(posedge sys_clk);
		rstn <= 1'b1;
		t_regs();
		t_rates();
		t_bill();
		t_fault();
		complete_run();
	end
endmodule // epfs_top_tb
